// [design/pss_consts.svh]
// Offsets, field positions and reset values of the power strap sampler.
// Assumes inclusion by bare name from the two modules.
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PSS_STATUS_OFS 8'h00
`define PSS_CTRL_OFS 8'h04

// ----------------------------------------
// Control fields
// ----------------------------------------
`define PSS_CTRL_STS_EN_BIT 0
`define PSS_CTRL_AFC_N_BIT 1
`define PSS_CTRL_REQ_LSB 4
`define PSS_CTRL_CHG_LSB 8
`define PSS_CTRL_WMASK 32'h00000FF3
`define PSS_CTRL_RST 32'h00000000

// ----------------------------------------
// Status fields
// ----------------------------------------
`define PSS_ST_FPM_N_BIT 0
`define PSS_ST_POL_BIT 1
`define PSS_ST_GANGED_BIT 2
`define PSS_ST_AUTO_N_BIT 3
`define PSS_ST_SERIAL_N_BIT 4
`define PSS_ST_ADDR1_BIT 5
`define PSS_ST_RUN_BIT 6
`define PSS_ST_SS_BIT 7
`define PSS_ST_PWR_LSB 8

// ----------------------------------------
// Strap reset values and bus answers
// ----------------------------------------
`define PSS_STRAP_RST 1'b1
`define PSS_POL_RST 1'b1
`define PSS_RESP_OKAY 2'h0
`define PSS_RESP_SLVERR 2'h2

`endif

// [design/pss_pkg.sv]
// Types shared by the power strap sampler modules.
// Assumes the constants header sits beside it.
package pss_pkg;
  typedef enum logic {PSS_PH_SAMPLE, PSS_PH_RUN} pss_phase_e;
  typedef enum logic [1:0] {PSS_REG_STATUS, PSS_REG_CTRL, PSS_REG_NONE} pss_reg_e;
endpackage

// [design/pss_port_power.sv]
// Per-port power control drivers with strap-selected polarity and ganging.
// Assumes enable, polarity and ganged come from latched straps.
`timescale 1ns/1ps
`include "pss_consts.svh"
module pss_port_power import pss_pkg::*; #(
  parameter int N_PORTS = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic polarity,
  input wire logic ganged,
  input wire logic [N_PORTS-1:0] request,
  output logic [N_PORTS-1:0] port_power_ctrl
);
  logic [N_PORTS-1:0] pwr_reg;
  logic [N_PORTS-1:0] pwr_next;
  logic any_req;

  assign any_req = |request;
  assign port_power_ctrl = pwr_reg;

  // ----------------------------------------
  // Port drivers
  // ----------------------------------------
  for (genvar i = 0; i < N_PORTS; i++) begin : g_port
    logic want;
    always_comb begin
      want = ganged ? any_req : request[i]; // see [R11]
      if (enable) begin
        pwr_next[i] = polarity ? want : ~want; // see [R3] see [R10]
      end else begin
        // Switching unsupported: hold every switch at its off level
        pwr_next[i] = ~polarity; // see [R2]
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_reg <= {N_PORTS{~`PSS_POL_RST}};
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Every ganged output must follow the OR of all requests, not merely agree with its neighbours
  gang_equal_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R11]
    enable && ganged |=> (port_power_ctrl == {N_PORTS{$past(polarity) ~^ (|$past(request))}}))
    else $error("ganged outputs differ");
  off_level_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R2]
    !enable |=> (port_power_ctrl == {N_PORTS{~$past(polarity)}}))
    else $error("disabled outputs not at off level");
  polarity_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R10]
    enable && !ganged |=> (port_power_ctrl == ($past(polarity) ? $past(request) : ~$past(request))))
    else $error("power control polarity wrong");
endmodule // pss_port_power

// [design/pss_strap_top.sv]
// Strap sampler of a four-port hub with an AXI4-Lite register slave.
// Assumes strap pins are stable and synchronous to aclk when reset is released.
//
// How it works
// [R1] Full power management strap is latched at reset release; low enables power switching.
// [R2] Strap high: power switching and over-current inputs are treated as unsupported; this design has no over-current inputs, only switching is held off.
// [R3] With switching enabled, four per-port power outputs drive the downstream switches.
// [R4] Board straps power management on for charging; strap initialises automatic full-current bit.
// [R5] Automatic charging on and full-current bit low: all divider charging modes allowed.
// [R6] Automatic charging on and full-current bit high: only highest-current divider mode used.
// [R7] In SMBus slave mode, slave address bit 1 comes from the shared pin level.
// [R8] After reset, with status output enabled, shared pin shows SuperSpeed upstream connection.
// [R9] Board must enable power switching for battery charging applications.
// [R10] Polarity strap: low makes power outputs active low, high active high.
// [R11] Ganged strap: low individual per-port control, high all ports switched together.
// [R12] Automatic charge strap: low enables automatic mode, high disables it.
// [R13] Serial mode strap: low selects SMBus slave, high selects I2C master.
// [R14] Latched strap values hold until the next reset whatever the pins do.
`timescale 1ns/1ps
`include "pss_consts.svh"
module pss_strap_top import pss_pkg::*; #(
  parameter int N_PORTS = 4,
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic full_power_mgmt_strap_n_i,
  output logic full_power_mgmt_strap_n_o,
  output logic full_power_mgmt_strap_n_oe,
  input wire logic power_ctrl_polarity,
  input wire logic ganged_strap,
  input wire logic auto_charge_enable_n,
  input wire logic serial_mode_select_n,
  input wire logic ss_connected,
  output logic [N_PORTS-1:0] port_power_ctrl,
  output logic [N_PORTS-1:0] port_charge_enable,
  output logic power_switching_enabled,
  output logic smbus_mode,
  output logic slave_addr_bit1,
  output logic charge_all_modes,
  output logic charge_highest_only
);
  function automatic pss_reg_e reg_decode(input logic [ADDR_W-1:0] addr);
    if (addr == ADDR_W'(`PSS_STATUS_OFS)) begin
      return PSS_REG_STATUS;
    end else if (addr == ADDR_W'(`PSS_CTRL_OFS)) begin
      return PSS_REG_CTRL;
    end
    return PSS_REG_NONE;
  endfunction

  // ----------------------------------------
  // Strap latch and shared pin
  // ----------------------------------------
  pss_phase_e phase_reg, phase_next;
  logic fpm_n_reg, fpm_n_next, pol_reg, pol_next, gang_reg, gang_next;
  logic auto_n_reg, auto_n_next, serial_n_reg, serial_n_next, addr1_reg, addr1_next;
  logic pin_oe_reg, pin_oe_next, pin_o_reg, pin_o_next;
  logic [31:0] ctrl_reg;
  logic run;

  always_comb begin
    phase_next = phase_reg;
    fpm_n_next = fpm_n_reg;
    pol_next = pol_reg;
    gang_next = gang_reg;
    auto_n_next = auto_n_reg;
    serial_n_next = serial_n_reg;
    addr1_next = addr1_reg;
    pin_oe_next = 1'b0;
    pin_o_next = 1'b0;
    if (phase_reg == PSS_PH_SAMPLE) begin
      // First edge after release: the pins still carry the strap levels
      fpm_n_next = full_power_mgmt_strap_n_i; // see [R1]
      pol_next = power_ctrl_polarity; // see [R10]
      gang_next = ganged_strap; // see [R11]
      auto_n_next = auto_charge_enable_n; // see [R12]
      serial_n_next = serial_mode_select_n; // see [R13]
      addr1_next = full_power_mgmt_strap_n_i; // see [R7]
      phase_next = PSS_PH_RUN; // see [R14]
    end else begin
      pin_oe_next = ctrl_reg[`PSS_CTRL_STS_EN_BIT]; // see [R8]
      pin_o_next = ctrl_reg[`PSS_CTRL_STS_EN_BIT] & ss_connected; // see [R8]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= PSS_PH_SAMPLE;
      fpm_n_reg <= `PSS_STRAP_RST;
      pol_reg <= `PSS_POL_RST;
      gang_reg <= `PSS_STRAP_RST;
      auto_n_reg <= `PSS_STRAP_RST;
      serial_n_reg <= `PSS_STRAP_RST;
      addr1_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
      pin_o_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      fpm_n_reg <= fpm_n_next;
      pol_reg <= pol_next;
      gang_reg <= gang_next;
      auto_n_reg <= auto_n_next;
      serial_n_reg <= serial_n_next;
      addr1_reg <= addr1_next;
      pin_oe_reg <= pin_oe_next;
      pin_o_reg <= pin_o_next;
    end
  end

  assign run = (phase_reg == PSS_PH_RUN);
  assign full_power_mgmt_strap_n_oe = pin_oe_reg;
  assign full_power_mgmt_strap_n_o = pin_o_reg;
  assign power_switching_enabled = run & ~fpm_n_reg; // see [R1] see [R2]
  assign smbus_mode = run & ~serial_n_reg; // see [R13]
  assign slave_addr_bit1 = smbus_mode & addr1_reg; // see [R7]
  assign charge_all_modes = run & ~auto_n_reg & ~ctrl_reg[`PSS_CTRL_AFC_N_BIT]; // see [R5]
  assign charge_highest_only = run & ~auto_n_reg & ctrl_reg[`PSS_CTRL_AFC_N_BIT]; // see [R6]
  assign port_charge_enable = ctrl_reg[`PSS_CTRL_CHG_LSB +: N_PORTS];

  pss_port_power #(.N_PORTS(N_PORTS)) u_port_power (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(power_switching_enabled),
    .polarity(pol_reg),
    .ganged(gang_reg),
    .request(ctrl_reg[`PSS_CTRL_REQ_LSB +: N_PORTS]),
    .port_power_ctrl(port_power_ctrl)
  );

  // ----------------------------------------
  // AXI4-Lite write side and control register
  // ----------------------------------------
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next, bvalid_reg, bvalid_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next, ctrl_next, wmask;
  logic [3:0] w_strb_reg, w_strb_next;
  logic [1:0] bresp_reg, bresp_next;
  logic do_write;

  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;

  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}} & `PSS_CTRL_WMASK;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (reg_decode(aw_addr_reg) == PSS_REG_NONE) ? `PSS_RESP_SLVERR : `PSS_RESP_OKAY;
      if (reg_decode(aw_addr_reg) == PSS_REG_CTRL) begin
        ctrl_next = (ctrl_reg & ~wmask) | (w_data_reg & wmask);
      end
    end
    // The strap seeds the full-current bit; software may override it later
    if (phase_reg == PSS_PH_SAMPLE) begin
      ctrl_next[`PSS_CTRL_AFC_N_BIT] = full_power_mgmt_strap_n_i; // see [R4]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `PSS_RESP_OKAY;
      ctrl_reg <= `PSS_CTRL_RST;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      ctrl_reg <= ctrl_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ----------------------------------------
  // AXI4-Lite read side
  // ----------------------------------------
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next, status_word;
  logic [1:0] rresp_reg, rresp_next;

  always_comb begin
    status_word = 32'h00000000;
    status_word[`PSS_ST_FPM_N_BIT] = fpm_n_reg;
    status_word[`PSS_ST_POL_BIT] = pol_reg;
    status_word[`PSS_ST_GANGED_BIT] = gang_reg;
    status_word[`PSS_ST_AUTO_N_BIT] = auto_n_reg;
    status_word[`PSS_ST_SERIAL_N_BIT] = serial_n_reg;
    status_word[`PSS_ST_ADDR1_BIT] = addr1_reg;
    status_word[`PSS_ST_RUN_BIT] = run;
    status_word[`PSS_ST_SS_BIT] = ss_connected;
    status_word[`PSS_ST_PWR_LSB +: N_PORTS] = port_power_ctrl;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = `PSS_RESP_OKAY;
      case (reg_decode(s_axi_araddr))
        PSS_REG_STATUS: rdata_next = status_word;
        PSS_REG_CTRL: rdata_next = ctrl_reg;
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = `PSS_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `PSS_RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence sample_then_run;
    (phase_reg == PSS_PH_SAMPLE) ##1 run;
  endsequence

  // Sampled aresetn keeps the last reset edge out of the antecedent
  strap_capture_a: assert property ( // see [R1]
    aresetn && (phase_reg == PSS_PH_SAMPLE) |=> (fpm_n_reg == $past(full_power_mgmt_strap_n_i)) && run)
    else $error("power management strap not captured");
  strap_hold_a: assert property (run ##1 run |-> $stable(fpm_n_reg) && $stable(pol_reg) // see [R14]
    && $stable(gang_reg) && $stable(auto_n_reg) && $stable(serial_n_reg) && $stable(addr1_reg))
    else $error("latched strap changed after sampling");
  full_current_init_a: assert property ( // see [R4]
    sample_then_run |-> ctrl_reg[`PSS_CTRL_AFC_N_BIT] == fpm_n_reg)
    else $error("full-current bit not seeded from strap");
  switch_support_a: assert property (run |-> power_switching_enabled == ~fpm_n_reg) // see [R2]
    else $error("switching support disagrees with strap");
  charge_modes_a: assert property (run && !auto_n_reg |-> // see [R5]
    (charge_all_modes != charge_highest_only) && (charge_highest_only == ctrl_reg[`PSS_CTRL_AFC_N_BIT]))
    else $error("divider charging mode choice wrong");
  auto_off_a: assert property (auto_n_reg |-> !charge_all_modes && !charge_highest_only) // see [R12]
    else $error("automatic charging active while disabled");
  slave_addr_a: assert property (sample_then_run |-> // see [R7]
    slave_addr_bit1 == (~$past(serial_mode_select_n) & $past(full_power_mgmt_strap_n_i)))
    else $error("slave address bit 1 wrong");
  status_pin_a: assert property (run && ctrl_reg[`PSS_CTRL_STS_EN_BIT] |=> // see [R8]
    full_power_mgmt_strap_n_oe && (full_power_mgmt_strap_n_o == $past(ss_connected)))
    else $error("connection status not driven");
  pin_quiet_a: assert property (!run |=> !full_power_mgmt_strap_n_oe) // see [R14]
    else $error("shared pin driven while sampling");
  serial_mode_a: assert property (run |-> smbus_mode == ~serial_n_reg) // see [R13]
    else $error("serial mode wrong");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
endmodule // pss_strap_top

// [verif/pss_board_model.sv]
// Board model: strap resistors on the hub strap pins and four port power switches.
// Assumes the bench chooses the strap set while the hub is held in reset.
`timescale 1ns/1ps
module pss_board_model (
  input wire logic [4:0] strap_set,
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic [3:0] port_power_ctrl,
  output logic pin_level,
  output logic power_ctrl_polarity,
  output logic ganged_strap,
  output logic auto_charge_enable_n,
  output logic serial_mode_select_n,
  output logic [3:0] switch_on
);
  // ----------------------------------------
  // Strap resistors
  // ----------------------------------------
  // Resistor only wins while the hub leaves the shared pin undriven
  assign pin_level = pin_oe ? pin_o : strap_set[0];
  assign power_ctrl_polarity = strap_set[1];
  assign ganged_strap = strap_set[2];
  assign auto_charge_enable_n = strap_set[3];
  assign serial_mode_select_n = strap_set[4];
  // ----------------------------------------
  // Power switches
  // ----------------------------------------
  // Switch enable level follows the polarity the board strapped
  assign switch_on = power_ctrl_polarity ? port_power_ctrl : ~port_power_ctrl;
endmodule // pss_board_model

// [verif/power_strap_sampling_test.sv]
// Self-checking bench of the strap sampler over AXI4-Lite.
// Assumes the board model beside it and the design package.
`timescale 1ns/1ps
module power_strap_sampling_test;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pin_o, pin_oe, pin_level, pol, gang, auto_n, ser_n;
  logic ss, pse, smb, addr1, all_m, hi_m, fpm;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, ppc, chg, sw;
  logic [1:0] bresp, rresp, rs;
  logic [4:0] strap_set, cfg;
  logic [4:0] cfgs [4] = '{5'h00, 5'h0E, 5'h15, 5'h09};
  int fail_count = 0;
  int num_checks = 0;
  always #4 aclk = ~aclk;
  pss_strap_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .full_power_mgmt_strap_n_i(pin_level),
    .full_power_mgmt_strap_n_o(pin_o), .full_power_mgmt_strap_n_oe(pin_oe), .power_ctrl_polarity(pol),
    .ganged_strap(gang), .auto_charge_enable_n(auto_n), .serial_mode_select_n(ser_n), .ss_connected(ss),
    .port_power_ctrl(ppc), .port_charge_enable(chg), .power_switching_enabled(pse), .smbus_mode(smb),
    .slave_addr_bit1(addr1), .charge_all_modes(all_m), .charge_highest_only(hi_m));
  pss_board_model board_u (.strap_set(strap_set), .pin_o(pin_o), .pin_oe(pin_oe), .port_power_ctrl(ppc),
    .pin_level(pin_level), .power_ctrl_polarity(pol), .ganged_strap(gang), .auto_charge_enable_n(auto_n),
    .serial_mode_select_n(ser_n), .switch_on(sw));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bound(input int n);
    if (n > 40) begin
      fail_count++;
      close_out();
    end
  endtask
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  // Each half is released at the edge that takes it; bready stays up until bvalid is seen
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
      bound(n);
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
      bound(n);
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  // Strap set bits: 0 power management, 1 polarity, 2 ganged, 3 auto charge, 4 serial mode
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, ss} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    strap_set = 5'h00;
    for (int c = 0; c < 4; c++) begin
      cfg = cfgs[c];
      fpm = cfg[0];
      @(posedge aclk);
      strap_set <= cfg;
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      strap_set <= ~cfg;
      settle(2);
      chk({pse, smb, addr1}, {!fpm, !cfg[4], !cfg[4] & fpm});
      chk({all_m, hi_m}, {!cfg[3] & !fpm, !cfg[3] & fpm});
      axi_rd(8'h00, rd, rs);
      chk(rd, {20'h0, {4{~cfg[1]}}, 2'b01, cfg[0], cfg});
      @(posedge aclk);
      strap_set <= cfg;
      settle(1);
      chk(sw, 4'h0);
      axi_rd(8'h04, rd, rs);
      chk(rd, {30'h0, fpm, 1'b0});
      chk(rs, 2'h0);
      // Charging is only enabled where the board straps power switching on
      axi_wr(8'h04, 32'h00000041 | {(fpm ? 4'h0 : 4'hA), 6'h00, fpm, 1'b0}, 2'h0);
      settle(2);
      chk(sw, !fpm ? (cfg[2] ? 4'hF : 4'h4) : 4'h0);
      chk(chg, fpm ? 4'h0 : 4'hA);
      @(posedge aclk);
      ss <= 1'b1;
      settle(2);
      chk({pin_oe, pin_o}, 2'b11);
      @(posedge aclk);
      ss <= 1'b0;
      settle(2);
      chk({pin_oe, pin_o}, 2'b10);
      if (c == 0) begin
        axi_wr(8'h10, 32'h00000FFF, 2'h2);
        axi_rd(8'h10, rd, rs);
        chk(rd, 32'h00000000);
        chk(rs, 2'h2);
        axi_wr(8'h00, 32'h00000FFF, 2'h0);
        axi_wr(8'h04, 32'h00000002, 2'h0);
        settle(1);
        chk({all_m, hi_m, sw}, {2'b01, 4'h0});
      end
    end
    close_out();
  end
endmodule // power_strap_sampling_test
